// File: core/cpr_param_regs.sv
// Charge parameter register bank with clamping, decode, watchdog defaults and top-off timing
`timescale 1ns/1ns
`default_nettype none
`include "cpr_regs.svh"

module cpr_param_regs #(
    parameter int unsigned TICKS_PER_SEC = `CPR_SECOND_NS / `CPR_CLK_NS
) (
    // Clock, reset, enable
    input  wire logic               mclk,
    input  wire logic               rst,
    input  wire logic               ce,
    // Register access from the serial slave
    input  wire logic               regWrEn,
    input  wire logic               regRdEn,
    input  wire cpr_pkg::cpr_byte_t regAddr,
    input  wire cpr_pkg::cpr_byte_t regWrData,
    output cpr_pkg::cpr_byte_t      regRdData,
    output logic                    regRdValid,
    // Register reset command
    input  wire logic               regResetReq,
    // Charger status
    input  wire logic               termCondition,
    // Decoded settings
    output logic [9:0]              prechargeMa,
    output logic [9:0]              termMa,
    output logic [12:0]             chargeVoltageMv,
    output logic [5:0]              fastChargeCurrentCode,
    output logic                    chargeInhibit,
    output logic [7:0]              rechargeOffsetMv,
    output logic                    termEnable,
    output logic                    fastTimerEn,
    output logic                    preTimerEn,
    output logic [3:0]              fastChargeLimitHrs,
    output logic [6:0]              thermalLimitC,
    output logic [5:0]              coldRangeScalePct,
    // Timers
    output logic                    chargeDone,
    output logic                    topOffActive,
    output logic                    wdExpired
);
    import cpr_pkg::*;

    cpr_byte_t         preTerm_ff;
    cpr_byte_t         volt_ff;
    cpr_byte_t         tmr_ff;
    cpr_byte_t         inb_ff;
    logic [5:0]        fast_ff;
    logic              wdRestart_ff;
    cpr_byte_t         rdData_ff;
    logic              rdValid_ff;
    cpr_topoff_state_t topState_ff;
    logic [11:0]       secLeft_ff;
    cpr_byte_t         rdMux;
    logic              secTick;
    logic              wdExp;
    logic              toDefault;
    logic              restartWr;
    logic [9:0]        preMa_ff;
    logic [9:0]        termMa_ff;
    logic [12:0]       voltMv_ff;
    logic [7:0]        rechgMv_ff;
    logic [3:0]        fastHrs_ff;
    logic [6:0]        thermC_ff;
    logic [5:0]        coldPct_ff;

    // Current code to mA: 60 mA per step over a 60 mA floor
    function automatic logic [9:0] codeToMa(input logic [3:0] code);
        codeToMa = 10'(code) * `CPR_I_STEP_MA + `CPR_I_OFF_MA;
    endfunction

    function automatic logic [7:0] wdSeconds(input logic [1:0] sel);
        case (sel)
            2'h1:    wdSeconds = `CPR_WD_40S;
            2'h2:    wdSeconds = `CPR_WD_80S;
            2'h3:    wdSeconds = `CPR_WD_160S;
            default: wdSeconds = 8'h0;
        endcase
    endfunction

    function automatic logic [11:0] extSeconds(input logic [1:0] sel);
        case (sel)
            2'h1:    extSeconds = `CPR_EXT_15M * `CPR_SEC_PER_M;
            2'h2:    extSeconds = `CPR_EXT_30M * `CPR_SEC_PER_M;
            2'h3:    extSeconds = `CPR_EXT_45M * `CPR_SEC_PER_M;
            default: extSeconds = 12'h0;
        endcase
    endfunction

    // Expiry restores defaults but leaves the boost/input byte alone
    assign toDefault = ce && (regResetReq || wdExp);
    assign restartWr = regWrEn && regAddr == `CPR_A_WDOG && regWrData[`CPR_B_RESTART];

    cpr_wdog_timer #(
        .TICKS_PER_SEC (TICKS_PER_SEC)
    ) u_wdog (
        .mclk      (mclk),
        .rst       (rst),
        .ce        (ce),
        .restart   (wdRestart_ff),
        .periodSec (wdSeconds(tmr_ff[`CPR_F_WDOG])),
        .secTick   (secTick),
        .expired   (wdExp)
    );

    // Restart bit: a register reset request in the same cycle wins over a new write
    always_ff @(posedge mclk) begin
        if (rst) begin
            wdRestart_ff <= 1'b0;
        end else if (ce) begin
            wdRestart_ff <= restartWr && !regResetReq;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            fast_ff <= `CPR_R_FAST;
        end else if (toDefault) begin
            fast_ff <= `CPR_R_FAST;
        end else if (ce && regWrEn && regAddr == `CPR_A_FAST) begin
            if (regWrData[`CPR_F_FAST] > `CPR_FAST_MAX) begin
                fast_ff <= `CPR_FAST_MAX;
            end else begin
                fast_ff <= regWrData[`CPR_F_FAST];
            end
        end
    end

    // Precharge stored as written; the limit applies where it is used
    always_ff @(posedge mclk) begin
        if (rst) begin
            preTerm_ff <= `CPR_R_PRE;
        end else if (toDefault) begin
            preTerm_ff <= `CPR_R_PRE;
        end else if (ce && regWrEn && regAddr == `CPR_A_PRE) begin
            preTerm_ff <= regWrData;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            volt_ff <= `CPR_R_VOLT;
        end else if (toDefault) begin
            volt_ff <= `CPR_R_VOLT;
        end else if (ce && regWrEn && regAddr == `CPR_A_VOLT) begin
            volt_ff <= regWrData;
            if (regWrData[`CPR_F_VCODE] > `CPR_VOLT_MAX) begin
                volt_ff[`CPR_F_VCODE] <= `CPR_VOLT_MAX;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            tmr_ff <= `CPR_R_TMR;
        end else if (toDefault) begin
            tmr_ff <= `CPR_R_TMR;
        end else if (ce && regWrEn && regAddr == `CPR_A_TMR) begin
            tmr_ff <= regWrData;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            inb_ff <= `CPR_R_INB;
        end else if (ce && regResetReq) begin
            inb_ff <= `CPR_R_INB;
        end else if (ce && regWrEn && regAddr == `CPR_A_INB) begin
            inb_ff <= regWrData;
        end
    end

    always_comb begin
        rdMux = 8'h00;
        case (regAddr)
            `CPR_A_WDOG: rdMux[`CPR_B_RESTART] = wdRestart_ff;
            `CPR_A_FAST: rdMux[`CPR_F_FAST] = fast_ff;
            `CPR_A_PRE:  rdMux = preTerm_ff;
            `CPR_A_VOLT: rdMux = volt_ff;
            `CPR_A_TMR:  rdMux = tmr_ff;
            `CPR_A_INB:  rdMux = inb_ff;
            default:     rdMux = 8'h00;
        endcase
    end

    // Read data valid one cycle after the request
    always_ff @(posedge mclk) begin
        if (rst) begin
            rdData_ff  <= 8'h00;
            rdValid_ff <= 1'b0;
        end else if (ce) begin
            rdValid_ff <= regRdEn;
            if (regRdEn) begin
                rdData_ff <= rdMux;
            end
        end
    end

    // Decoded analog targets, registered
    always_ff @(posedge mclk) begin
        if (rst) begin
            preMa_ff   <= codeToMa(4'(`CPR_R_PRE >> 4));
            termMa_ff  <= codeToMa(4'(`CPR_R_PRE));
            voltMv_ff  <= `CPR_V_OFF_MV;
            rechgMv_ff <= `CPR_RECHG_LO;
            fastHrs_ff <= `CPR_FAST_10H;
            thermC_ff  <= `CPR_THERM_HI;
            coldPct_ff <= `CPR_COLD_FIFTH;
        end else if (ce) begin
            if (preTerm_ff[`CPR_F_PRE] > `CPR_PRE_MAX) begin
                preMa_ff <= codeToMa(`CPR_PRE_MAX);
            end else begin
                preMa_ff <= codeToMa(preTerm_ff[`CPR_F_PRE]);
            end
            termMa_ff <= codeToMa(preTerm_ff[`CPR_F_TERM]);
            if (volt_ff[`CPR_F_VCODE] == `CPR_VOLT_SPEC) begin
                voltMv_ff <= `CPR_V_SPEC_MV;
            end else begin
                voltMv_ff <= 13'(volt_ff[`CPR_F_VCODE]) * `CPR_V_STEP_MV + `CPR_V_OFF_MV;
            end
            rechgMv_ff <= volt_ff[`CPR_B_RECHG] ? `CPR_RECHG_HI : `CPR_RECHG_LO;
            fastHrs_ff <= tmr_ff[`CPR_B_FASTLIM] ? `CPR_FAST_10H : `CPR_FAST_5H;
            thermC_ff  <= tmr_ff[`CPR_B_THERM] ? `CPR_THERM_HI : `CPR_THERM_LO;
            coldPct_ff <= tmr_ff[`CPR_B_COLD] ? `CPR_COLD_FIFTH : `CPR_COLD_HALF;
        end
    end

    // Top-off extension: counts whole seconds after termination is met
    always_ff @(posedge mclk) begin
        if (rst) begin
            topState_ff <= TO_IDLE;
            secLeft_ff  <= 12'h0;
        end else if (ce) begin
            case (topState_ff)
                TO_IDLE: begin
                    if (tmr_ff[`CPR_B_TERMEN] && termCondition) begin
                        if (volt_ff[`CPR_F_EXT] == 2'h0) begin
                            topState_ff <= TO_DONE;
                        end else begin
                            topState_ff <= TO_EXTEND;
                            secLeft_ff  <= extSeconds(volt_ff[`CPR_F_EXT]);
                        end
                    end
                end
                TO_EXTEND: begin
                    if (!tmr_ff[`CPR_B_TERMEN]) begin
                        topState_ff <= TO_IDLE;
                    end else if (secTick) begin
                        if (secLeft_ff <= 12'h1) begin
                            topState_ff <= TO_DONE;
                        end
                        secLeft_ff <= secLeft_ff - 12'h1;
                    end
                end
                TO_DONE: begin
                    // Leaves when termination is withdrawn or disabled, so recharge can restart
                    if (!tmr_ff[`CPR_B_TERMEN] || !termCondition) begin
                        topState_ff <= TO_IDLE;
                    end
                end
                default: topState_ff <= TO_IDLE;
            endcase
        end
    end

    assign regRdData             = rdData_ff;
    assign regRdValid            = rdValid_ff;
    assign prechargeMa           = preMa_ff;
    assign termMa                = termMa_ff;
    assign chargeVoltageMv       = voltMv_ff;
    assign fastChargeCurrentCode = fast_ff;
    assign chargeInhibit         = (fast_ff == `CPR_FAST_OFF);
    assign rechargeOffsetMv      = rechgMv_ff;
    assign termEnable            = tmr_ff[`CPR_B_TERMEN];
    assign fastTimerEn           = tmr_ff[`CPR_B_SAFETY];
    assign preTimerEn            = tmr_ff[`CPR_B_SAFETY];
    assign fastChargeLimitHrs    = fastHrs_ff;
    assign thermalLimitC         = thermC_ff;
    assign coldRangeScalePct     = coldPct_ff;
    assign chargeDone            = (topState_ff == TO_DONE);
    assign topOffActive          = (topState_ff == TO_EXTEND);
    assign wdExpired             = wdExp;

    AST_VOLT_NEVER_ABOVE_MAX: assert property (@(posedge mclk) disable iff (rst)
        volt_ff[`CPR_F_VCODE] <= `CPR_VOLT_MAX) else $error("voltage code above limit");

    AST_FAST_WRITE_CLAMP: assert property (@(posedge mclk) disable iff (rst)
        ce && !toDefault && regWrEn && regAddr == `CPR_A_FAST && regWrData[`CPR_F_FAST] > `CPR_FAST_MAX
        |=> fast_ff == `CPR_FAST_MAX) else $error("fast current not clamped");

    AST_PRE_LIMIT: assert property (@(posedge mclk) disable iff (rst)
        ce && preTerm_ff[`CPR_F_PRE] > `CPR_PRE_MAX |=> prechargeMa == `CPR_I_PRE_LIM)
        else $error("precharge current not limited");

    AST_SPECIAL_VOLT: assert property (@(posedge mclk) disable iff (rst)
        ce && volt_ff[`CPR_F_VCODE] == `CPR_VOLT_SPEC |=> chargeVoltageMv == `CPR_V_SPEC_MV)
        else $error("special voltage not selected");

    AST_NO_EXTENSION: assert property (@(posedge mclk) disable iff (rst)
        ce && topState_ff == TO_IDLE && termCondition && termEnable && volt_ff[`CPR_F_EXT] == 2'h0
        |=> chargeDone && !topOffActive) else $error("termination delayed with top-off off");

    AST_TERM_SUPPRESSED: assert property (@(posedge mclk) disable iff (rst)
        ce && !termEnable |=> !chargeDone) else $error("termination while disabled");

    AST_EXPIRY_DEFAULTS: assert property (@(posedge mclk) disable iff (rst)
        ce && wdExp |=> preTerm_ff == `CPR_R_PRE && volt_ff == `CPR_R_VOLT && tmr_ff == `CPR_R_TMR
        && fast_ff == `CPR_R_FAST) else $error("defaults not restored on expiry");

    AST_RESTART_SELF_CLEAR: assert property (@(posedge mclk) disable iff (rst)
        wdRestart_ff && ce && !restartWr |=> !wdRestart_ff ##1 !wdRestart_ff || $past(restartWr))
        else $error("restart bit did not clear");

    AST_READ_BACK: assert property (@(posedge mclk) disable iff (rst)
        ce && regRdEn && regAddr == `CPR_A_TMR |=> regRdValid && regRdData == $past(tmr_ff))
        else $error("read data mismatch");

endmodule
`default_nettype wire

// File: pkg/cpr_regs.svh
// Register map, field positions, reset values and timing constants of the charge parameter bank
`ifndef CPR_REGS_SVH
`define CPR_REGS_SVH

// Byte addresses
`define CPR_A_WDOG     8'h01
`define CPR_A_FAST     8'h02
`define CPR_A_PRE      8'h03
`define CPR_A_VOLT     8'h04
`define CPR_A_TMR      8'h05
`define CPR_A_INB      8'h06

// Reset values
`define CPR_R_PRE      8'h22
`define CPR_R_VOLT     8'h58
`define CPR_R_TMR      8'h9F
`define CPR_R_INB      8'h66
`define CPR_R_FAST     6'h22

// Field positions
`define CPR_B_RESTART  6
`define CPR_F_FAST     5:0
`define CPR_F_PRE      7:4
`define CPR_F_TERM     3:0
`define CPR_F_VCODE    7:3
`define CPR_F_EXT      2:1
`define CPR_B_RECHG    0
`define CPR_B_TERMEN   7
`define CPR_F_WDOG     5:4
`define CPR_B_SAFETY   3
`define CPR_B_FASTLIM  2
`define CPR_B_THERM    1
`define CPR_B_COLD     0

// Code limits
`define CPR_PRE_MAX    4'hC
`define CPR_VOLT_MAX   5'h18
`define CPR_VOLT_SPEC  5'h0F
`define CPR_FAST_MAX   6'h32
`define CPR_FAST_OFF   6'h00

// Analog targets
`define CPR_I_STEP_MA  10'h03C
`define CPR_I_OFF_MA   10'h03C
`define CPR_I_PRE_LIM  10'h30C
`define CPR_V_OFF_MV   13'h0F07
`define CPR_V_STEP_MV  13'h0020
`define CPR_V_SPEC_MV  13'h10F7
`define CPR_RECHG_LO   8'h64
`define CPR_RECHG_HI   8'hC8
`define CPR_FAST_5H    4'h5
`define CPR_FAST_10H   4'hA
`define CPR_THERM_LO   7'h5A
`define CPR_THERM_HI   7'h6E
`define CPR_COLD_HALF  6'h32
`define CPR_COLD_FIFTH 6'h14

// Timing
`define CPR_WD_40S     8'h28
`define CPR_WD_80S     8'h50
`define CPR_WD_160S    8'hA0
`define CPR_EXT_15M    12'h00F
`define CPR_EXT_30M    12'h01E
`define CPR_EXT_45M    12'h02D
`define CPR_SEC_PER_M  12'h03C
`define CPR_CLK_NS     10
`define CPR_SECOND_NS  1000000000

`endif

// File: pkg/cpr_pkg.sv
// Types shared by the charge parameter bank
`default_nettype none
package cpr_pkg;
    typedef logic [7:0] cpr_byte_t;
    typedef enum logic [1:0] {
        TO_IDLE,
        TO_EXTEND,
        TO_DONE
    } cpr_topoff_state_t;
endpackage
`default_nettype wire

// File: core/cpr_wdog_timer.sv
// One-second tick generator and serial watchdog counter
`timescale 1ns/1ns
`default_nettype none
`include "cpr_regs.svh"

module cpr_wdog_timer #(
    parameter int unsigned TICKS_PER_SEC = `CPR_SECOND_NS / `CPR_CLK_NS
) (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       ce,
    // Control
    input  wire logic       restart,
    input  wire logic [7:0] periodSec,
    // Status
    output logic            secTick,
    output logic            expired
);
    logic [31:0] preCnt_ff;
    logic [7:0]  secCnt_ff;
    logic        secTick_ff;
    logic        expired_ff;

    // Free running so the top-off timer keeps its pace across restarts
    always_ff @(posedge mclk) begin
        if (rst) begin
            preCnt_ff  <= 32'h0;
            secTick_ff <= 1'b0;
        end else if (ce) begin
            secTick_ff <= (preCnt_ff == 32'(TICKS_PER_SEC - 1));
            if (preCnt_ff == 32'(TICKS_PER_SEC - 1)) begin
                preCnt_ff <= 32'h0;
            end else begin
                preCnt_ff <= preCnt_ff + 32'h1;
            end
        end
    end

    // Restart granularity is one second
    always_ff @(posedge mclk) begin
        if (rst) begin
            secCnt_ff  <= 8'h0;
            expired_ff <= 1'b0;
        end else if (ce && (restart || periodSec == 8'h0)) begin
            // Gated by ce so a restart held while frozen cannot move the count
            secCnt_ff  <= 8'h0;
            expired_ff <= 1'b0;
        end else if (ce) begin
            expired_ff <= 1'b0;
            if (secTick_ff) begin
                if (secCnt_ff >= periodSec - 8'h1) begin
                    secCnt_ff  <= 8'h0;
                    expired_ff <= 1'b1;
                end else begin
                    secCnt_ff <= secCnt_ff + 8'h1;
                end
            end
        end
    end

    assign secTick = secTick_ff;
    assign expired = expired_ff;

endmodule
`default_nettype wire

// File: verification/cpr_host_model.sv
// Host side of the register port: single byte writes and reads
`timescale 1ns/1ns
`default_nettype none
`include "cpr_regs.svh"

module cpr_host_model (
    // Clock
    input  wire logic               mclk,
    // Register port
    output logic                    regWrEn,
    output logic                    regRdEn,
    output cpr_pkg::cpr_byte_t      regAddr,
    output cpr_pkg::cpr_byte_t      regWrData,
    input  wire cpr_pkg::cpr_byte_t regRdData,
    input  wire logic               regRdValid
);
    import cpr_pkg::*;

    time wrDoneAt;
    time rdDoneAt;

    initial begin
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regAddr = 8'hFF;
        regWrData = 8'hFF;
        wrDoneAt = 0;
        rdDoneAt = 0;
    end

    // Entered at a falling edge; the strobe spans exactly one rising edge
    task automatic write_reg(input cpr_byte_t addr, input cpr_byte_t data);
        // A strobe just lowered is not raised again in the same time step
        if (wrDoneAt == $time) begin
            @(negedge mclk);
        end
        regAddr = addr;
        regWrData = data;
        regWrEn = 1'b1;
        @(negedge mclk);
        regWrEn = 1'b0;
        wrDoneAt = $time;
    endtask

    // A missing valid pulse returns unknown so every compare fails
    task automatic read_reg(input cpr_byte_t addr, output cpr_byte_t data);
        if (rdDoneAt == $time) begin
            @(negedge mclk);
        end
        regAddr = addr;
        regRdEn = 1'b1;
        @(negedge mclk);
        regRdEn = 1'b0;
        rdDoneAt = $time;
        data = (regRdValid === 1'b1) ? regRdData : 8'hXX;
    endtask

    task automatic restart_wdog;
        write_reg(`CPR_A_WDOG, 8'h40);
    endtask
endmodule
`default_nettype wire

// File: verification/cpr_param_regs_tb_top.sv
// Self-checking bench for the charge parameter register bank
`timescale 1ns/1ns
`default_nettype none
`include "cpr_regs.svh"

module cpr_param_regs_tb_top;
    import cpr_pkg::*;
    localparam int LIMIT = 60000;
    logic        mclk, rst, ce, regResetReq, termCondition;
    logic        regWrEn, regRdEn, regRdValid, chargeInhibit, termEnable;
    logic        fastTimerEn, preTimerEn, chargeDone, topOffActive, wdExpired;
    cpr_byte_t   regAddr, regWrData, regRdData, rdv;
    logic [9:0]  prechargeMa, termMa;
    logic [12:0] chargeVoltageMv;
    logic [5:0]  fastChargeCurrentCode, coldRangeScalePct;
    logic [7:0]  rechargeOffsetMv;
    logic [3:0]  fastChargeLimitHrs;
    logic [6:0]  thermalLimitC;
    int          errors, checked, cycles;

    cpr_param_regs #(.TICKS_PER_SEC(10)) i_cpr_param_regs (
        .mclk(mclk), .rst(rst), .ce(ce),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
        .regRdData(regRdData), .regRdValid(regRdValid), .regResetReq(regResetReq),
        .termCondition(termCondition), .prechargeMa(prechargeMa), .termMa(termMa),
        .chargeVoltageMv(chargeVoltageMv), .fastChargeCurrentCode(fastChargeCurrentCode),
        .chargeInhibit(chargeInhibit), .rechargeOffsetMv(rechargeOffsetMv), .termEnable(termEnable),
        .fastTimerEn(fastTimerEn), .preTimerEn(preTimerEn), .fastChargeLimitHrs(fastChargeLimitHrs),
        .thermalLimitC(thermalLimitC), .coldRangeScalePct(coldRangeScalePct), .chargeDone(chargeDone),
        .topOffActive(topOffActive), .wdExpired(wdExpired)
    );

    cpr_host_model i_cpr_host_model (
        .mclk(mclk), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
        .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid)
    );

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chkf(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input cpr_byte_t a, input cpr_byte_t d);
        i_cpr_host_model.write_reg(a, d);
    endtask

    task automatic rdc(input cpr_byte_t a, input cpr_byte_t exp);
        i_cpr_host_model.read_reg(a, rdv);
        chk({8'h00, rdv}, {8'h00, exp});
    endtask

    // Registered decoded outputs trail the register by one further cycle
    task automatic settle;
        repeat (2) @(negedge mclk);
    endtask

    task automatic t_defaults;
        rdc(`CPR_A_FAST, 8'h22);
        chk(16'(fastChargeCurrentCode), 16'h0022);
        rdc(`CPR_A_PRE, 8'h22);
        rdc(`CPR_A_VOLT, 8'h58);
        rdc(`CPR_A_TMR, 8'h9F);
        rdc(`CPR_A_INB, 8'h66);
        rdc(`CPR_A_WDOG, 8'h00);
        rdc(8'h07, 8'h00);
        chk(16'(prechargeMa), 16'd180);
        chk(16'(termMa), 16'd180);
        chk(16'(chargeVoltageMv), 16'd4199);
        chk(16'(rechargeOffsetMv), 16'd100);
        chkf(termEnable, 1'b1);
        chkf(fastTimerEn & preTimerEn, 1'b1);
        chk(16'(fastChargeLimitHrs), 16'd10);
        chk(16'(thermalLimitC), 16'd110);
        chk(16'(coldRangeScalePct), 16'd20);
        chkf(chargeInhibit | topOffActive | chargeDone, 1'b0);
    endtask

    task automatic t_codes;
        wr(`CPR_A_PRE, 8'hF5);
        rdc(`CPR_A_PRE, 8'hF5);
        settle();
        chk(16'(prechargeMa), 16'd780);
        chk(16'(termMa), 16'd360);
        wr(`CPR_A_PRE, 8'hB0);
        settle();
        chk(16'(prechargeMa), 16'd720);
        chk(16'(termMa), 16'd60);
        wr(`CPR_A_VOLT, 8'h7B);
        settle();
        chk(16'(chargeVoltageMv), 16'd4343);
        chk(16'(rechargeOffsetMv), 16'd200);
        wr(`CPR_A_VOLT, 8'h70);
        settle();
        chk(16'(chargeVoltageMv), 16'd4295);
        wr(`CPR_A_VOLT, 8'hFF);
        rdc(`CPR_A_VOLT, 8'hC7);
        settle();
        chk(16'(chargeVoltageMv), 16'd4615);
        wr(`CPR_A_FAST, 8'h3F);
        rdc(`CPR_A_FAST, 8'h32);
        chk(16'(fastChargeCurrentCode), 16'h0032);
        wr(`CPR_A_FAST, 8'h00);
        settle();
        chkf(chargeInhibit, 1'b1);
    endtask

    task automatic t_timerctl;
        ce = 1'b0;
        wr(`CPR_A_PRE, 8'h11);
        ce = 1'b1;
        rdc(`CPR_A_PRE, 8'hB0);
        wr(`CPR_A_TMR, 8'h40);
        wr(`CPR_A_INB, 8'h12);
        rdc(`CPR_A_TMR, 8'h40);
        termCondition = 1'b1;
        settle();
        chkf(termEnable | chargeDone, 1'b0);
        chkf(fastTimerEn | preTimerEn, 1'b0);
        chk(16'(fastChargeLimitHrs), 16'd5);
        chk(16'(thermalLimitC), 16'd90);
        chk(16'(coldRangeScalePct), 16'd50);
        termCondition = 1'b0;
        regResetReq = 1'b1;
        @(negedge mclk);
        regResetReq = 1'b0;
        rdc(`CPR_A_TMR, 8'h9F);
        rdc(`CPR_A_VOLT, 8'h58);
        rdc(`CPR_A_FAST, 8'h22);
        rdc(`CPR_A_INB, 8'h66);
    endtask

    task automatic t_watchdog;
        int n;
        i_cpr_host_model.restart_wdog();
        rdc(`CPR_A_WDOG, 8'h40);
        rdc(`CPR_A_WDOG, 8'h00);
        wr(`CPR_A_PRE, 8'h55);
        wr(`CPR_A_INB, 8'h12);
        n = 0;
        while (wdExpired !== 1'b1 && n < 500) begin
            @(negedge mclk);
            n++;
        end
        chkf(n >= 380 && n <= 405, 1'b1);
        @(negedge mclk);
        chkf(wdExpired, 1'b0);
        rdc(`CPR_A_PRE, 8'h22);
        rdc(`CPR_A_INB, 8'h12);
    endtask

    task automatic t_topoff;
        int n;
        wr(`CPR_A_TMR, 8'h8F);
        settle();
        termCondition = 1'b1;
        @(negedge mclk);
        chkf(chargeDone, 1'b1);
        chkf(topOffActive, 1'b0);
        termCondition = 1'b0;
        settle();
        chkf(chargeDone, 1'b0);
        for (int e = 1; e < 4; e++) begin
            wr(`CPR_A_VOLT, cpr_byte_t'(8'h58 | (e << 1)));
            settle();
            termCondition = 1'b1;
            @(negedge mclk);
            chkf(topOffActive & ~chargeDone, 1'b1);
            n = 0;
            while (chargeDone !== 1'b1 && n < 28000) begin
                @(negedge mclk);
                n++;
            end
            chkf(n >= 9000 * e - 12 && n <= 9000 * e + 3, 1'b1);
            termCondition = 1'b0;
            settle();
            chkf(chargeDone | topOffActive, 1'b0);
        end
    endtask

    task automatic complete_run;
        $display("checked=%0d errors=%0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Whole run needs about 54500 cycles, mostly the three top-off waits
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            errors++;
            complete_run();
        end
    end

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        regResetReq = 1'b0;
        termCondition = 1'b0;
        errors = 0;
        checked = 0;
        cycles = 0;
        repeat (6) @(negedge mclk);
        rst = 1'b0;
        t_defaults();
        t_codes();
        t_timerctl();
        t_watchdog();
        t_topoff();
        complete_run();
    end
endmodule
`default_nettype wire
